/* File: mxlb_pkg.sv */
// Constants and types shared by the max-address lock and block-size command logic.
package mxlb_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Task-file register addresses (host address lines, three bits).
   ////////////////////////////////////////////////////////////////////////////////

   // Data port, 16 bits wide, used for the password sector.
   localparam logic [2:0] MXLB_ADR_DATA = 3'h0;
   // Feature select on write, error report on read.
   localparam logic [2:0] MXLB_ADR_FEAT_ERR = 3'h1;
   // Sector count, read and write.
   localparam logic [2:0] MXLB_ADR_SCNT = 3'h2;
   // Device and head select, read and write.
   localparam logic [2:0] MXLB_ADR_DEVHEAD = 3'h6;
   // Command code on write, drive status on read.
   localparam logic [2:0] MXLB_ADR_CMD_STAT = 3'h7;

   ////////////////////////////////////////////////////////////////////////////////
   // Command codes and maximum-address feature values.
   ////////////////////////////////////////////////////////////////////////////////

   localparam logic [7:0] MXLB_CMD_READ_NATIVE = 8'hF8;
   localparam logic [7:0] MXLB_CMD_SET_MAX = 8'hF9;
   localparam logic [7:0] MXLB_CMD_SET_MULT = 8'hC6;
   localparam logic [7:0] MXLB_FEAT_SET_PWD = 8'h01;
   localparam logic [7:0] MXLB_FEAT_LOCK = 8'h02;
   localparam logic [7:0] MXLB_FEAT_UNLOCK = 8'h03;
   localparam logic [7:0] MXLB_FEAT_FREEZE = 8'h04;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions of the error and status registers.
   ////////////////////////////////////////////////////////////////////////////////

   localparam int MXLB_ERR_ABT_BIT = 2;
   localparam int MXLB_STAT_BSY_BIT = 7;
   localparam int MXLB_STAT_RDY_BIT = 6;
   localparam int MXLB_STAT_DF_BIT = 5;
   localparam int MXLB_STAT_DSC_BIT = 4;
   localparam int MXLB_STAT_DRQ_BIT = 3;
   localparam int MXLB_STAT_ERR_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Sector layout, counts and reset values.
   ////////////////////////////////////////////////////////////////////////////////

   // Last word index of a 256-word sector.
   localparam logic [7:0] MXLB_LAST_WORD = 8'hFF;
   // Password occupies words 1 through 16.
   localparam logic [7:0] MXLB_PWD_FIRST = 8'h01;
   localparam logic [7:0] MXLB_PWD_LAST = 8'h10;
   // Unlock attempts granted after power-on or hardware reset.
   localparam logic [2:0] MXLB_TRIES_RST = 3'h5;
   // Block size after reset: read/write multiple disabled.
   localparam logic [7:0] MXLB_BLK_RST = 8'h00;
   localparam logic [7:0] MXLB_DEVHEAD_RST = 8'hA0;

   ////////////////////////////////////////////////////////////////////////////////
   // State types.
   ////////////////////////////////////////////////////////////////////////////////

   // Command sequencer states.
   typedef enum logic [1:0] {MXLB_IDLE, MXLB_EXEC, MXLB_XFER, MXLB_CHECK} mxlb_seq_e;

   // Maximum-address security states.
   typedef enum logic [1:0] {MXLB_UNLOCKED, MXLB_LOCKED, MXLB_FROZEN} mxlb_sec_e;

endpackage : mxlb_pkg

/* File: mxlb_core.sv */
// Command interpreter for max-address security subcommands and the set-multiple command.
`timescale 1ns/10ps

// Behaviour
// RULE_01 - Feature 02h without prior native read locks
// RULE_02 - After native read, any subcommand sets max
// RULE_03 - Locked state rejects all but unlock, freeze
// RULE_04 - Locked holds until reset, unlock or freeze
// RULE_05 - Unlock takes one sector, compares stored password
// RULE_06 - Mismatch aborts and decrements attempt counter
// RULE_07 - Attempt counter starts at five, mismatch-only
// RULE_08 - Counter at zero rejects unlock until reset
// RULE_09 - Match enters unlocked, all commands accepted
// RULE_10 - Freeze rejects set, password, lock, unlock after
// RULE_11 - Set multiple enables multiple, records block size
// RULE_12 - Block size valid only 0,2,4,8,16
// RULE_13 - Block size zero disables multiple commands
// RULE_14 - Invalid size aborts and disables multiple
// RULE_15 - Password kept only until power cycle
// RULE_16 - Password is words 1 to 16
// RULE_17 - Forbidden commands in locked/frozen report abort
// RULE_18 - Reject sets abort and error, clears busy
// RULE_19 - Track native read; other command completion clears
module mxlb_core
   import mxlb_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Task-file register port from the host.
   input wire logic [2:0] tf_addr,
   input wire logic tf_wr,
   input wire logic tf_rd,
   input wire logic [15:0] tf_wdata,
   output logic [15:0] tf_rdata,
   // Command completion pulse, the interrupt request for each finished command.
   output logic cmd_done,
   // Block state seen by the rest of the drive.
   output logic mult_enable,
   output logic [7:0] mult_block_size,
   output logic [1:0] max_sec_state,
   output logic [2:0] unlock_tries
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions.
   ////////////////////////////////////////////////////////////////////////////////

   // Accepts only the block sizes that the read and write multiple engine supports.
   function automatic logic mxlb_blk_valid(input logic [7:0] size);
      logic ok;
      ok = 1'b0;
      case (size)
         8'h00, 8'h02, 8'h04, 8'h08, 8'h10: ok = 1'b1; // RULE_12
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : mxlb_blk_valid

   // True while the word index falls inside the password field of the sector.
   function automatic logic mxlb_in_pwd(input logic [7:0] idx);
      return (idx >= MXLB_PWD_FIRST) && (idx <= MXLB_PWD_LAST); // RULE_16
   endfunction : mxlb_in_pwd

   ////////////////////////////////////////////////////////////////////////////////
   // State record.
   ////////////////////////////////////////////////////////////////////////////////

   // Everything the block remembers lives in this one record.
   typedef struct packed {
      mxlb_seq_e seq;            // Command sequencer state.
      mxlb_sec_e sec;            // Max-address security state.
      logic native;              // Previous command was a native max read.
      logic [2:0] tries;         // Remaining unlock attempts.
      logic [15:0][15:0] pwd;    // Stored password, volatile.
      logic [7:0] feat;          // Feature select register.
      logic [7:0] scnt;          // Sector count register.
      logic [7:0] devhead;       // Device and head select register.
      logic [7:0] cmd;           // Command code being executed.
      logic xfer_unlock;         // Sector feeds a compare rather than a store.
      logic [7:0] widx;          // Word index inside the data sector.
      logic miss;                // Some password word differed.
      logic abt;                 // Abort flag of the last command.
      logic mult_en;             // Read/write multiple enabled.
      logic [7:0] blk;           // Recorded block size.
      logic [15:0] rdata;        // Registered read data.
      logic done;                // One-cycle completion pulse.
   } mxlb_state_s;

   // Registered state and its next value.
   mxlb_state_s st_ff;
   mxlb_state_s nxt_st;

   // Status byte built from the current state; busy during execute and compare.
   logic [7:0] status_byte;
   // Error byte carrying only the abort bit.
   logic [7:0] error_byte;

   ////////////////////////////////////////////////////////////////////////////////
   // Read-back register images.
   ////////////////////////////////////////////////////////////////////////////////

   // Device fault is never raised here, so a rejected command shows busy and fault clear.
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[MXLB_STAT_BSY_BIT] = (st_ff.seq == MXLB_EXEC) || (st_ff.seq == MXLB_CHECK);
      status_byte[MXLB_STAT_RDY_BIT] = 1'b1;
      status_byte[MXLB_STAT_DF_BIT] = 1'b0; // RULE_18
      status_byte[MXLB_STAT_DSC_BIT] = 1'b1;
      status_byte[MXLB_STAT_DRQ_BIT] = (st_ff.seq == MXLB_XFER);
      status_byte[MXLB_STAT_ERR_BIT] = st_ff.abt; // RULE_18
      error_byte = 8'h00;
      error_byte[MXLB_ERR_ABT_BIT] = st_ff.abt; // RULE_18
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   ////////////////////////////////////////////////////////////////////////////////

   // One process decides every field; execution of a command takes one busy cycle,
   // and the sector transfer is paced entirely by host data writes.
   always_comb
   begin
      logic abort;
      logic start_xfer;
      logic keep_native;
      logic finish;
      abort = 1'b0;
      start_xfer = 1'b0;
      keep_native = 1'b0;
      finish = 1'b0;
      nxt_st = st_ff;
      nxt_st.done = 1'b0;

      // Host register reads return a registered image one cycle later.
      if (tf_rd)
      begin
         case (tf_addr)
            MXLB_ADR_FEAT_ERR: nxt_st.rdata = {8'h00, error_byte};
            MXLB_ADR_SCNT: nxt_st.rdata = {8'h00, st_ff.scnt};
            MXLB_ADR_DEVHEAD: nxt_st.rdata = {8'h00, st_ff.devhead};
            MXLB_ADR_CMD_STAT: nxt_st.rdata = {8'h00, status_byte};
            default: nxt_st.rdata = 16'h0000; // Data port and unused addresses read zero.
         endcase
      end

      case (st_ff.seq)
         MXLB_IDLE:
         begin
            // Parameter registers are written only while the device is idle.
            if (tf_wr)
            begin
               case (tf_addr)
                  MXLB_ADR_FEAT_ERR: nxt_st.feat = tf_wdata[7:0];
                  MXLB_ADR_SCNT: nxt_st.scnt = tf_wdata[7:0];
                  MXLB_ADR_DEVHEAD: nxt_st.devhead = tf_wdata[7:0];
                  MXLB_ADR_CMD_STAT:
                  begin
                     // A new command clears the previous error and goes busy.
                     nxt_st.cmd = tf_wdata[7:0];
                     nxt_st.abt = 1'b0;
                     nxt_st.seq = MXLB_EXEC;
                  end
                  default: nxt_st.seq = MXLB_IDLE; // Stray data writes are dropped.
               endcase
            end
         end

         MXLB_EXEC:
         begin
            case (st_ff.cmd)
               MXLB_CMD_READ_NATIVE:
               begin
                  // Remember this so the next set-max is read as a plain set.
                  keep_native = 1'b1; // RULE_19
               end
               MXLB_CMD_SET_MAX:
               begin
                  if (st_ff.native)
                  begin
                     // Feature ignored; plain set refused unless unlocked.
                     abort = (st_ff.sec != MXLB_UNLOCKED); // RULE_02 RULE_17
                  end
                  else
                  begin
                     case (st_ff.feat)
                        MXLB_FEAT_SET_PWD:
                        begin
                           // New password needs an unlocked, unfrozen device.
                           abort = (st_ff.sec != MXLB_UNLOCKED); // RULE_17 RULE_10
                           start_xfer = !abort;
                           nxt_st.xfer_unlock = 1'b0;
                        end
                        MXLB_FEAT_LOCK:
                        begin
                           abort = (st_ff.sec != MXLB_UNLOCKED); // RULE_03 RULE_10
                           if (!abort)
                           begin
                              nxt_st.sec = MXLB_LOCKED; // RULE_01 RULE_03
                           end
                        end
                        MXLB_FEAT_UNLOCK:
                        begin
                           // Exhausted attempts refuse before any data moves.
                           abort = (st_ff.sec == MXLB_FROZEN) || (st_ff.tries == 3'h0); // RULE_08 RULE_10
                           start_xfer = !abort; // RULE_05
                           nxt_st.xfer_unlock = 1'b1;
                        end
                        MXLB_FEAT_FREEZE:
                        begin
                           // Freeze is legal from locked too; only a second one is refused.
                           abort = (st_ff.sec == MXLB_FROZEN); // RULE_10
                           if (!abort)
                           begin
                              nxt_st.sec = MXLB_FROZEN; // RULE_04 RULE_10
                           end
                        end
                        default: abort = 1'b1; // Unknown subcommand.
                     endcase
                  end
               end
               MXLB_CMD_SET_MULT:
               begin
                  if (mxlb_blk_valid(st_ff.scnt))
                  begin
                     nxt_st.blk = st_ff.scnt; // RULE_11
                     nxt_st.mult_en = (st_ff.scnt != 8'h00); // RULE_11 RULE_13
                  end
                  else
                  begin
                     abort = 1'b1; // RULE_14
                     nxt_st.blk = MXLB_BLK_RST; // RULE_14
                     nxt_st.mult_en = 1'b0; // RULE_14
                  end
               end
               default: abort = 1'b0; // Other commands are handled elsewhere in the drive.
            endcase

            if (start_xfer)
            begin
               // Data request phase; the native mark is spent by this command.
               nxt_st.seq = MXLB_XFER;
               nxt_st.widx = 8'h00;
               nxt_st.miss = 1'b0;
               nxt_st.native = 1'b0; // RULE_19
            end
            else
            begin
               finish = 1'b1;
            end
         end

         MXLB_XFER:
         begin
            // Every data-port write consumes one word; only words 1..16 matter.
            if (tf_wr && (tf_addr == MXLB_ADR_DATA))
            begin
               if (mxlb_in_pwd(st_ff.widx))
               begin
                  if (st_ff.xfer_unlock)
                  begin
                     nxt_st.miss = st_ff.miss
                        | (st_ff.pwd[4'(st_ff.widx - MXLB_PWD_FIRST)] != tf_wdata); // RULE_05
                  end
                  else
                  begin
                     nxt_st.pwd[4'(st_ff.widx - MXLB_PWD_FIRST)] = tf_wdata; // RULE_16
                  end
               end
               nxt_st.widx = st_ff.widx + 8'h01;
               if (st_ff.widx == MXLB_LAST_WORD)
               begin
                  nxt_st.seq = MXLB_CHECK;
               end
            end
         end

         MXLB_CHECK:
         begin
            if (!st_ff.xfer_unlock)
            begin
               // Accepted password leaves the device unlocked.
               nxt_st.sec = MXLB_UNLOCKED;
            end
            else if (st_ff.miss)
            begin
               abort = 1'b1; // RULE_06
               nxt_st.tries = st_ff.tries - 3'h1; // RULE_06 RULE_07
            end
            else
            begin
               nxt_st.sec = MXLB_UNLOCKED; // RULE_09 RULE_04
            end
            finish = 1'b1;
         end

         default: nxt_st.seq = MXLB_IDLE;
      endcase

      // Common completion: busy drops, error reflects the outcome, interrupt pulses.
      if (finish)
      begin
         nxt_st.seq = MXLB_IDLE;
         nxt_st.abt = abort; // RULE_18 RULE_17
         nxt_st.done = 1'b1;
         nxt_st.native = keep_native; // RULE_19
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.
   ////////////////////////////////////////////////////////////////////////////////

   // Reset is the power cycle as far as this logic knows: password, attempts and
   // security state all return to their initial values.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff.seq <= MXLB_IDLE;
         st_ff.sec <= MXLB_UNLOCKED;
         st_ff.native <= 1'b0;
         st_ff.tries <= MXLB_TRIES_RST; // RULE_07 RULE_08
         st_ff.pwd <= '0; // RULE_15
         st_ff.feat <= 8'h00;
         st_ff.scnt <= 8'h00;
         st_ff.devhead <= MXLB_DEVHEAD_RST;
         st_ff.cmd <= 8'h00;
         st_ff.xfer_unlock <= 1'b0;
         st_ff.widx <= 8'h00;
         st_ff.miss <= 1'b0;
         st_ff.abt <= 1'b0;
         st_ff.mult_en <= 1'b0;
         st_ff.blk <= MXLB_BLK_RST;
         st_ff.rdata <= 16'h0000;
         st_ff.done <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all taken straight from the state register.
   ////////////////////////////////////////////////////////////////////////////////

   assign tf_rdata = st_ff.rdata;
   assign cmd_done = st_ff.done;
   assign mult_enable = st_ff.mult_en;
   assign mult_block_size = st_ff.blk;
   assign max_sec_state = st_ff.sec;
   assign unlock_tries = st_ff.tries;

endmodule : mxlb_core

/* File: mxlb_core_asserts.sv */
// Concurrent checks on the ports of the max-address lock and block-size logic.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module mxlb_core_asserts
   import mxlb_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Task-file port.
   input wire logic [2:0] tf_addr,
   input wire logic tf_wr,
   input wire logic tf_rd,
   input wire logic [15:0] tf_wdata,
   input wire logic [15:0] tf_rdata,
   // Block state.
   input wire logic cmd_done,
   input wire logic mult_enable,
   input wire logic [7:0] mult_block_size,
   input wire logic [1:0] max_sec_state,
   input wire logic [2:0] unlock_tries
);
   // One domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Attempts only ever fall by one, and only as a command ends.
   tries_step_a: assert property ($changed(unlock_tries) |-> cmd_done &&
      unlock_tries == $past(unlock_tries) - 3'h1) else $error("unlock tries stepped wrongly");
   tries_zero_a: assert property (unlock_tries == 3'h0 |=> unlock_tries == 3'h0)
      else $error("unlock tries left zero without reset");
   tries_cap_a: assert property (unlock_tries <= MXLB_TRIES_RST)
      else $error("unlock tries above start value");
   // The security state moves only when a command completes.
   state_move_a: assert property ($changed(max_sec_state) |-> cmd_done)
      else $error("security state moved without completion");
   frozen_hold_a: assert property (max_sec_state == 2'h2 |=> max_sec_state == 2'h2)
      else $error("frozen state left");
   // Leaving the locked state must not cost an attempt.
   unlock_free_a: assert property ($changed(max_sec_state) && max_sec_state == 2'h0 |->
      $stable(unlock_tries) && $past(max_sec_state) == 2'h1) else $error("bad unlock move");
   state_legal_a: assert property (max_sec_state != 2'h3)
      else $error("illegal security state");
   size_valid_a: assert property (mult_block_size inside {8'h00, 8'h02, 8'h04, 8'h08, 8'h10})
      else $error("block size not a legal value");
   mult_match_a: assert property (mult_enable == (mult_block_size != 8'h00))
      else $error("multiple enable disagrees with block size");
   size_move_a: assert property ($changed(mult_block_size) |-> cmd_done)
      else $error("block size moved without completion");
   done_pulse_a: assert property (cmd_done |=> !cmd_done)
      else $error("completion pulse longer than one cycle");

   // Main scenarios reached.
   cover property (max_sec_state == 2'h1);
   cover property (max_sec_state == 2'h2);
   cover property (unlock_tries == 3'h0);
   cover property (mult_enable && mult_block_size == 8'h10);
endmodule : mxlb_core_asserts

bind mxlb_core mxlb_core_asserts u_mxlb_core_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
   .tf_addr(tf_addr), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata),
   .cmd_done(cmd_done), .mult_enable(mult_enable), .mult_block_size(mult_block_size),
   .max_sec_state(max_sec_state), .unlock_tries(unlock_tries));

/* File: mxlb_host_model.sv */
// Host controller model that drives the task-file registers of the drive.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module mxlb_host_model
   import mxlb_pkg::*;
(
   // Clock.
   input wire logic clk_sys,
   // Task-file port towards the drive.
   output logic [2:0] tf_addr,
   output logic tf_wr,
   output logic tf_rd,
   output logic [15:0] tf_wdata,
   input wire logic [15:0] tf_rdata
);
   // Idle bus at time zero.
   initial
   begin
      tf_addr = 3'h0;
      tf_wr = 1'b0;
      tf_rd = 1'b0;
      tf_wdata = 16'h0000;
   end

   // One-cycle write strobe; the data lines show the inverse once released.
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      #1;
      tf_addr = a;
      tf_wdata = d;
      tf_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      tf_wr = 1'b0;
      tf_wdata = ~d;
   endtask : wr

   // One-cycle read strobe; data is registered by the drive at the sampling edge.
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      #1;
      tf_addr = a;
      tf_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      tf_rd = 1'b0;
      d = tf_rdata;
   endtask : rd

   // Whole sector, word 0 first; reserved words carry ones so they must be ignored.
   task automatic send_sector(input logic [15:0] pwd);
      for (int i = 0; i < 256; i++)
         wr(MXLB_ADR_DATA, (i >= 1 && i <= 16) ? pwd : 16'hFFFF);
   endtask : send_sector
endmodule : mxlb_host_model

/* File: testbench.sv */
// Self-checking bench for the max-address lock and block-size logic.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module testbench
   import mxlb_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] tf_addr;
   logic tf_wr;
   logic tf_rd;
   logic [15:0] tf_wdata;
   logic [15:0] tf_rdata;
   logic cmd_done;
   logic mult_enable;
   logic [7:0] mult_block_size;
   logic [1:0] max_sec_state;
   logic [2:0] unlock_tries;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int done_cnt = 0;
   logic [7:0] sizes [8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h10, 8'h00, 8'h20};
   logic [7:0] frz [4] = '{MXLB_FEAT_SET_PWD, MXLB_FEAT_LOCK, MXLB_FEAT_UNLOCK, MXLB_FEAT_FREEZE};
   logic ok;

   always #4 clk_sys = ~clk_sys;

   mxlb_core u_mxlb_core (.clk_sys(clk_sys), .rst_n(rst_n), .tf_addr(tf_addr), .tf_wr(tf_wr),
      .tf_rd(tf_rd), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata), .cmd_done(cmd_done),
      .mult_enable(mult_enable), .mult_block_size(mult_block_size),
      .max_sec_state(max_sec_state), .unlock_tries(unlock_tries));

   mxlb_host_model u_mxlb_host_model (.clk_sys(clk_sys), .tf_addr(tf_addr), .tf_wr(tf_wr),
      .tf_rd(tf_rd), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata));

   // Completions are counted so a task never misses a pulse that came early.
   always @(posedge clk_sys)
   begin
      if (cmd_done === 1'b1)
         done_cnt <= done_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Issues one command, sends a sector if asked and the drive wants one, then checks status.
   task automatic run(input logic [7:0] feat, input logic [7:0] code, input logic [15:0] pwd,
      input logic send, input logic ab);
      int n0;
      int t;
      logic [15:0] st;
      n0 = done_cnt;
      u_mxlb_host_model.wr(MXLB_ADR_FEAT_ERR, {8'h00, feat});
      u_mxlb_host_model.wr(MXLB_ADR_CMD_STAT, {8'h00, code});
      if (send)
      begin
         repeat (3) @(posedge clk_sys);
         u_mxlb_host_model.rd(MXLB_ADR_CMD_STAT, st);
         if (st[MXLB_STAT_DRQ_BIT] === 1'b1)
            u_mxlb_host_model.send_sector(pwd);
      end
      t = 0;
      while (done_cnt == n0 && t < 50)
      begin
         @(posedge clk_sys);
         t++;
      end
      chk("done", 16'(done_cnt != n0), 16'h0001);
      u_mxlb_host_model.rd(MXLB_ADR_CMD_STAT, st);
      chk("status", st & 16'h00A9, {15'h0000, ab});
      u_mxlb_host_model.rd(MXLB_ADR_FEAT_ERR, st);
      chk("error", st & 16'h0004, ab ? 16'h0004 : 16'h0000);
   endtask : run

   initial
   begin
      repeat (12) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      chk("tries", 16'(unlock_tries), 16'h0005);
      chk("mult", {8'h00, mult_block_size}, 16'h0000);
      $display("test reset done");
      // Legal and illegal block sizes; an illegal one after 16 must disable.
      foreach (sizes[i])
      begin
         ok = sizes[i] inside {8'h00, 8'h02, 8'h04, 8'h08, 8'h10};
         u_mxlb_host_model.wr(MXLB_ADR_SCNT, {8'h00, sizes[i]});
         run(8'h00, MXLB_CMD_SET_MULT, 16'h0000, 1'b0, !ok);
         chk("size", {8'h00, mult_block_size}, ok ? {8'h00, sizes[i]} : 16'h0000);
         chk("enable", 16'(mult_enable), 16'(ok && sizes[i] != 8'h00));
      end
      $display("test block size done");
      // Store a non-default password so later compares prove what is kept.
      run(MXLB_FEAT_SET_PWD, MXLB_CMD_SET_MAX, 16'h1234, 1'b1, 1'b0);
      // After a native read the lock feature is a plain set-max.
      run(8'h00, MXLB_CMD_READ_NATIVE, 16'h0000, 1'b0, 1'b0);
      run(MXLB_FEAT_LOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b0);
      chk("state", 16'(max_sec_state), 16'h0000);
      // Any other command in between clears the native mark, so this one locks.
      run(8'h00, MXLB_CMD_READ_NATIVE, 16'h0000, 1'b0, 1'b0);
      run(8'h00, MXLB_CMD_SET_MULT, 16'h0000, 1'b0, 1'b1);
      run(MXLB_FEAT_LOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b0);
      chk("state", 16'(max_sec_state), 16'h0001);
      run(MXLB_FEAT_SET_PWD, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b1);
      run(MXLB_FEAT_LOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b1);
      chk("state", 16'(max_sec_state), 16'h0001);
      $display("test lock done");
      run(MXLB_FEAT_UNLOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b1, 1'b1);
      chk("tries", 16'(unlock_tries), 16'h0004);
      run(MXLB_FEAT_UNLOCK, MXLB_CMD_SET_MAX, 16'h1234, 1'b1, 1'b0);
      chk("state", 16'(max_sec_state), 16'h0000);
      chk("tries", 16'(unlock_tries), 16'h0004);
      $display("test unlock done");
      // Exhaust the attempts; then a further unlock is refused before any data moves.
      run(MXLB_FEAT_LOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         run(MXLB_FEAT_UNLOCK, MXLB_CMD_SET_MAX, 16'hA5A5, 1'b1, 1'b1);
         chk("tries", 16'(unlock_tries), 16'(3 - i));
      end
      run(MXLB_FEAT_UNLOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b1, 1'b1);
      chk("state", 16'(max_sec_state), 16'h0001);
      chk("tries", 16'(unlock_tries), 16'h0000);
      $display("test exhaust done");
      run(MXLB_FEAT_FREEZE, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b0);
      chk("state", 16'(max_sec_state), 16'h0002);
      foreach (frz[i])
         run(frz[i], MXLB_CMD_SET_MAX, 16'h0000, 1'b1, 1'b1);
      run(8'h00, MXLB_CMD_READ_NATIVE, 16'h0000, 1'b0, 1'b0);
      run(MXLB_FEAT_LOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b0, 1'b1);
      chk("state", 16'(max_sec_state), 16'h0002);
      $display("test freeze done");
      // A reset restores the attempts and the default password.
      @(posedge clk_sys);
      #1;
      rst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      chk("tries", 16'(unlock_tries), 16'h0005);
      chk("state", 16'(max_sec_state), 16'h0000);
      run(MXLB_FEAT_UNLOCK, MXLB_CMD_SET_MAX, 16'h0000, 1'b1, 1'b0);
      chk("tries", 16'(unlock_tries), 16'h0005);
      $display("test reset again done");
      summarize();
   end
endmodule : testbench
